// ---- src/cfq_top.sv ----
// CAN port frame handling: ID range filter toward fiber, queue toward CAN.
// Assumes an APB master on CLOCK and a CAN controller that takes frames at bus rate.
//
// Function
// [RULE1] Range filter enable per port, off at reset; off passes every frame.
// [RULE2] Filter acts only on CAN-to-fiber frames, never on fiber-to-CAN.
// [RULE3] Standard frames pass when the 11-bit ID lies in its range.
// [RULE4] Extended frames pass when the 29-bit ID lies in its range.
// [RULE5] Queue depth set in units of ten frames, default 65535 units; the code caps it at 64 frames.
// [RULE6] Fiber frames are queued and released at the CAN controller pace.
// [RULE7] Full queue drops the new frame, or optionally the oldest one.
// [RULE8] In TCP mode an optional flush empties the queue on connect.
// [RULE9] Up to 200 server connections, at most 6 client or UDP segments.
// [RULE10] Every frame crosses the fiber side as a 13-byte record.
// [RULE11] Bounds are inclusive; the format flag picks the range.
// [RULE12] Settings are read live and apply to frames arriving after a change.
`timescale 1ns/1ps
`include "cfq_consts.svh"
module cfq_top (
  input  wire logic                   CLOCK,
  input  wire logic                   RSTN,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [11:0]            PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic                   CAN_RX_VALID,
  input  wire cfq_pkg::cfq_rec_t      CAN_RX_REC,
  output logic                        FIB_TX_VALID,
  output cfq_pkg::cfq_rec_t           FIB_TX_REC,
  input  wire logic                   FIB_RX_VALID,
  input  wire cfq_pkg::cfq_rec_t      FIB_RX_REC,
  output logic                        CAN_TX_VALID,
  output cfq_pkg::cfq_rec_t           CAN_TX_REC,
  input  wire logic                   CAN_TX_READY,
  input  wire logic                   CONN_OPEN_REQ,
  input  wire logic                   CONN_CLOSE,
  output logic                        CONN_GRANT,
  output logic                        CONN_REJECT
);
  // Inclusive range test, shared by both frame formats
  function automatic logic in_range(input logic [28:0] v, input logic [28:0] lo,
                                    input logic [28:0] hi);
    in_range = (v >= lo) && (v <= hi);                             // [RULE11]
  endfunction

  // Frames held = units x 10, clipped to the storage actually present
  function automatic logic [`CFQ_CNT_W-1:0] cap_limit(input logic [15:0] units);
    logic [19:0] frames;
    frames = {4'h0, units} * `CFQ_FRAMES_PER_UNIT;                 // [RULE5]
    if (frames > `CFQ_MEM_DEPTH_W) begin
      cap_limit = `CFQ_CNT_W'(`CFQ_MEM_DEPTH);
    end else begin
      cap_limit = frames[`CFQ_CNT_W-1:0];
    end
  endfunction

  cfq_q_if qi ();

  logic                   filt_en_q, filt_en_d;
  logic                   drop_old_q, drop_old_d;
  logic                   flush_conn_q, flush_conn_d;
  cfq_pkg::cfq_netmode_t  mode_q, mode_d;
  logic [10:0]            std_lo_q, std_lo_d, std_hi_q, std_hi_d;
  logic [28:0]            ext_lo_q, ext_lo_d, ext_hi_q, ext_hi_d;
  logic [15:0]            qunits_q, qunits_d;
  logic [2:0]             conn_cfg_q, conn_cfg_d;
  logic [31:0]            prdata_q, prdata_d;
  logic                   pready_q, pready_d, pslverr_q, pslverr_d;
  logic                   wr_fire, rd_hit;
  logic [31:0]            rd_word;
  // Counters and connection state sit here because the read mux needs them first
  logic [15:0]            filtered_q, filtered_d, qdrops_q, qdrops_d;
  logic [7:0]             active_q, active_d, conn_limit;

  // APB: access phase is answered on its second cycle; writes land on that edge
  always_comb begin
    pready_d  = PSEL && PENABLE && !pready_q;
    wr_fire   = PSEL && PENABLE && pready_q && PWRITE;
    rd_hit    = 1'b1;
    rd_word   = 32'h00000000;
    if (PADDR == `CFQ_OFS_CTRL) begin
      rd_word[`CFQ_CTRL_FILT_EN]    = filt_en_q;
      rd_word[`CFQ_CTRL_DROP_OLD]   = drop_old_q;
      rd_word[`CFQ_CTRL_FLUSH_CONN] = flush_conn_q;
      rd_word[`CFQ_CTRL_MODE_MSB:`CFQ_CTRL_MODE_LSB] = mode_q;
    end else if (PADDR == `CFQ_OFS_STD_LO) begin
      rd_word[10:0] = std_lo_q;
    end else if (PADDR == `CFQ_OFS_STD_HI) begin
      rd_word[10:0] = std_hi_q;
    end else if (PADDR == `CFQ_OFS_EXT_LO) begin
      rd_word[28:0] = ext_lo_q;
    end else if (PADDR == `CFQ_OFS_EXT_HI) begin
      rd_word[28:0] = ext_hi_q;
    end else if (PADDR == `CFQ_OFS_QUNITS) begin
      rd_word[15:0] = qunits_q;
    end else if (PADDR == `CFQ_OFS_CONN) begin
      rd_word[2:0] = conn_cfg_q;
    end else if (PADDR == `CFQ_OFS_STATUS) begin
      rd_word[`CFQ_CNT_W-1:0] = qi.count;
      rd_word[23:16]          = active_q;
    end else if (PADDR == `CFQ_OFS_STATS) begin
      rd_word = {filtered_q, qdrops_q};
    end else begin
      rd_hit = 1'b0;
    end
    prdata_d  = pready_d && !PWRITE ? rd_word : prdata_q;
    pslverr_d = pready_d && !rd_hit;
  end

  // Writable settings; read-only offsets ignore writes
  always_comb begin
    filt_en_d    = filt_en_q;
    drop_old_d   = drop_old_q;
    flush_conn_d = flush_conn_q;
    mode_d       = mode_q;
    std_lo_d     = std_lo_q;
    std_hi_d     = std_hi_q;
    ext_lo_d     = ext_lo_q;
    ext_hi_d     = ext_hi_q;
    qunits_d     = qunits_q;
    conn_cfg_d   = conn_cfg_q;
    if (wr_fire) begin
      if (PADDR == `CFQ_OFS_CTRL) begin
        filt_en_d    = PWDATA[`CFQ_CTRL_FILT_EN];                  // [RULE1]
        drop_old_d   = PWDATA[`CFQ_CTRL_DROP_OLD];                 // [RULE7]
        flush_conn_d = PWDATA[`CFQ_CTRL_FLUSH_CONN];               // [RULE8]
        if (PWDATA[`CFQ_CTRL_MODE_MSB:`CFQ_CTRL_MODE_LSB] != 2'h3) begin
          mode_d = cfq_pkg::cfq_netmode_t'(PWDATA[`CFQ_CTRL_MODE_MSB:`CFQ_CTRL_MODE_LSB]);
        end
      end else if (PADDR == `CFQ_OFS_STD_LO) begin
        std_lo_d = PWDATA[10:0];
      end else if (PADDR == `CFQ_OFS_STD_HI) begin
        std_hi_d = PWDATA[10:0];
      end else if (PADDR == `CFQ_OFS_EXT_LO) begin
        ext_lo_d = PWDATA[28:0];
      end else if (PADDR == `CFQ_OFS_EXT_HI) begin
        ext_hi_d = PWDATA[28:0];
      end else if (PADDR == `CFQ_OFS_QUNITS) begin
        qunits_d = PWDATA[15:0];                                   // [RULE5]
      end else if (PADDR == `CFQ_OFS_CONN) begin
        // Segment count is clamped so software cannot exceed the table size
        conn_cfg_d = (PWDATA[31:0] > 32'h00000006) ? `CFQ_SEG_MAX : PWDATA[2:0]; // [RULE9]
      end
    end
  end

  // Register file and bus answer
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      filt_en_q    <= `CFQ_RST_FILT_EN;
      drop_old_q   <= `CFQ_RST_DROP_OLD;
      flush_conn_q <= `CFQ_RST_FLUSH_CONN;
      mode_q       <= cfq_pkg::CFQ_NM_SERVER;
      std_lo_q     <= `CFQ_RST_STD_LO;
      std_hi_q     <= `CFQ_RST_STD_HI;
      ext_lo_q     <= `CFQ_RST_EXT_LO;
      ext_hi_q     <= `CFQ_RST_EXT_HI;
      qunits_q     <= `CFQ_RST_QUNITS;
      conn_cfg_q   <= `CFQ_RST_CONN_CFG;
      prdata_q     <= 32'h00000000;
      pready_q     <= 1'b0;
      pslverr_q    <= 1'b0;
    end else begin
      filt_en_q    <= filt_en_d;
      drop_old_q   <= drop_old_d;
      flush_conn_q <= flush_conn_d;
      mode_q       <= mode_d;
      std_lo_q     <= std_lo_d;
      std_hi_q     <= std_hi_d;
      ext_lo_q     <= ext_lo_d;
      ext_hi_q     <= ext_hi_d;
      qunits_q     <= qunits_d;
      conn_cfg_q   <= conn_cfg_d;
      prdata_q     <= prdata_d;
      pready_q     <= pready_d;
      pslverr_q    <= pslverr_d;
    end
  end

  // CAN to fiber path: one register stage with the range filter in front
  logic               fib_v_q, fib_v_d, accept;
  cfq_pkg::cfq_rec_t  fib_rec_q, fib_rec_d;
  logic               is_ext;
  logic [28:0]        rx_id;

  always_comb begin
    is_ext = CAN_RX_REC[`CFQ_INFO_FF_BIT];                         // [RULE11]
    rx_id  = CAN_RX_REC[`CFQ_ID_LSB+28:`CFQ_ID_LSB];               // [RULE10]
    if (!filt_en_q) begin
      accept = 1'b1;                                               // [RULE1]
    end else if (is_ext) begin
      accept = in_range(rx_id, ext_lo_q, ext_hi_q);                // [RULE4] [RULE12]
    end else begin
      accept = in_range({18'h00000, rx_id[10:0]}, {18'h00000, std_lo_q},
                        {18'h00000, std_hi_q});                    // [RULE3] [RULE12]
    end
    fib_v_d    = CAN_RX_VALID && accept;
    fib_rec_d  = CAN_RX_VALID ? CAN_RX_REC : fib_rec_q;
    filtered_d = filtered_q;
    if (CAN_RX_VALID && !accept && filtered_q != 16'hFFFF) begin
      filtered_d = filtered_q + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      fib_v_q    <= 1'b0;
      fib_rec_q  <= '0;
      filtered_q <= 16'h0000;
    end else begin
      fib_v_q    <= fib_v_d;
      fib_rec_q  <= fib_rec_d;
      filtered_q <= filtered_d;
    end
  end

  // Connection accounting; a granted TCP connect may flush the queue
  logic        grant_q, grant_d, reject_q, reject_d, do_flush;

  always_comb begin
    conn_limit = (mode_q == cfq_pkg::CFQ_NM_SERVER) ? `CFQ_SERVER_CONN_MAX
                                                     : {5'h00, conn_cfg_q}; // [RULE9]
    grant_d    = CONN_OPEN_REQ && (active_q < conn_limit);          // [RULE9]
    reject_d   = CONN_OPEN_REQ && !grant_d;
    active_d   = active_q;
    if (grant_d && !(CONN_CLOSE && active_q != 8'h00)) begin
      active_d = active_q + 8'h01;
    end else if (!grant_d && CONN_CLOSE && active_q != 8'h00) begin
      active_d = active_q - 8'h01;
    end
    do_flush = grant_d && flush_conn_q && (mode_q != cfq_pkg::CFQ_NM_UDP); // [RULE8]
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      active_q <= 8'h00;
      grant_q  <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      active_q <= active_d;
      grant_q  <= grant_d;
      reject_q <= reject_d;
    end
  end

  // Fiber to CAN path: unfiltered into the queue, out through a holding stage
  logic               can_v_q, can_v_d, load;
  cfq_pkg::cfq_rec_t  can_rec_q, can_rec_d;

  assign qi.push_valid = FIB_RX_VALID;                             // [RULE2] [RULE6]
  assign qi.push_rec   = FIB_RX_REC;                               // [RULE10]
  assign qi.pop        = load;
  assign qi.flush      = do_flush;
  assign qi.drop_old   = drop_old_q;
  assign qi.limit      = cap_limit(qunits_q);                      // [RULE12]

  // The holding stage refills when it is empty or when the CAN side takes the frame
  always_comb begin
    load      = !qi.empty && !do_flush && (!can_v_q || CAN_TX_READY); // [RULE6]
    can_v_d   = can_v_q;
    can_rec_d = can_rec_q;
    if (do_flush) begin
      can_v_d = 1'b0;                                              // [RULE8]
    end else if (load) begin
      can_v_d   = 1'b1;
      can_rec_d = qi.head_rec;
    end else if (CAN_TX_READY) begin
      can_v_d = 1'b0;
    end
    qdrops_d = qdrops_q;
    if (qi.dropped && qdrops_q != 16'hFFFF) begin
      qdrops_d = qdrops_q + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      can_v_q   <= 1'b0;
      can_rec_q <= '0;
      qdrops_q  <= 16'h0000;
    end else begin
      can_v_q   <= can_v_d;
      can_rec_q <= can_rec_d;
      qdrops_q  <= qdrops_d;
    end
  end

  cfq_queue u_queue (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .q     (qi)
  );

  assign PRDATA       = prdata_q;
  assign PREADY       = pready_q;
  assign PSLVERR      = pslverr_q;
  assign FIB_TX_VALID = fib_v_q;
  assign FIB_TX_REC   = fib_rec_q;
  assign CAN_TX_VALID = can_v_q;
  assign CAN_TX_REC   = can_rec_q;
  assign CONN_GRANT   = grant_q;
  assign CONN_REJECT  = reject_q;
endmodule // cfq_top

// ---- src/cfq_consts.svh ----
// Constants for the CAN port frame filter and transmit queue.
// Assumes inclusion by both design modules; definitions only.
`ifndef CFQ_CONSTS_SVH
`define CFQ_CONSTS_SVH

// One fiber record is 13 bytes: info, 4 ID bytes, 8 data bytes
`define CFQ_REC_W            104
`define CFQ_INFO_FF_BIT      103
`define CFQ_ID_MSB           95
`define CFQ_ID_LSB           64
// Physical queue storage; capacity in frames is the lesser of this and ten times the setting
`define CFQ_MEM_DEPTH        64
`define CFQ_PTR_W            6
`define CFQ_CNT_W            7
`define CFQ_MEM_DEPTH_W      20'h00040
`define CFQ_FRAMES_PER_UNIT  20'h0000A

// Register byte offsets
`define CFQ_OFS_CTRL         12'h000
`define CFQ_OFS_STD_LO       12'h004
`define CFQ_OFS_STD_HI       12'h008
`define CFQ_OFS_EXT_LO       12'h00C
`define CFQ_OFS_EXT_HI       12'h010
`define CFQ_OFS_QUNITS       12'h014
`define CFQ_OFS_CONN         12'h018
`define CFQ_OFS_STATUS       12'h01C
`define CFQ_OFS_STATS        12'h020

// CTRL field positions
`define CFQ_CTRL_FILT_EN     0
`define CFQ_CTRL_DROP_OLD    1
`define CFQ_CTRL_FLUSH_CONN  2
`define CFQ_CTRL_MODE_LSB    4
`define CFQ_CTRL_MODE_MSB    5

// Reset values
`define CFQ_RST_FILT_EN      1'h0
`define CFQ_RST_DROP_OLD     1'h0
`define CFQ_RST_FLUSH_CONN   1'h1
`define CFQ_RST_STD_LO       11'h000
`define CFQ_RST_STD_HI       11'h7FF
`define CFQ_RST_EXT_LO       29'h00000000
`define CFQ_RST_EXT_HI       29'h1FFFFFFF
`define CFQ_RST_QUNITS       16'hFFFF
`define CFQ_RST_CONN_CFG     3'h1

// Connection limits
`define CFQ_SERVER_CONN_MAX  8'hC8
`define CFQ_SEG_MAX          3'h6
`endif

// ---- src/cfq_pkg.sv ----
// Types shared by the CAN port frame filter and transmit queue.
// Assumes nothing beyond the constants header.
`include "cfq_consts.svh"
package cfq_pkg;
  typedef logic [`CFQ_REC_W-1:0] cfq_rec_t;
  // Network working mode of the port
  typedef enum logic [1:0] {
    CFQ_NM_SERVER = 2'h0,
    CFQ_NM_CLIENT = 2'h1,
    CFQ_NM_UDP    = 2'h2
  } cfq_netmode_t;
endpackage

// ---- src/cfq_q_if.sv ----
// Link between the port top and its transmit queue.
// Assumes one clock; all signals are same-domain.
`timescale 1ns/1ps
`include "cfq_consts.svh"
interface cfq_q_if;
  logic                   push_valid;
  cfq_pkg::cfq_rec_t      push_rec;
  logic                   pop;
  logic                   flush;
  logic                   drop_old;
  logic [`CFQ_CNT_W-1:0]  limit;
  logic [`CFQ_CNT_W-1:0]  count;
  logic                   empty;
  cfq_pkg::cfq_rec_t      head_rec;
  logic                   dropped;
  modport owner (output push_valid, push_rec, pop, flush, drop_old, limit,
                 input count, empty, head_rec, dropped);
  modport queue (input push_valid, push_rec, pop, flush, drop_old, limit,
                 output count, empty, head_rec, dropped);
endinterface

// ---- src/cfq_queue.sv ----
// Transmit queue for frames from fiber toward CAN, with full policy.
// Assumes pop is only raised while the queue is not empty.
`timescale 1ns/1ps
`include "cfq_consts.svh"
module cfq_queue (
  input  wire logic  clk,
  input  wire logic  rst_n,
  cfq_q_if.queue     q
);
  cfq_pkg::cfq_rec_t      mem [`CFQ_MEM_DEPTH];
  logic [`CFQ_PTR_W-1:0]  rd_q, rd_d, wr_q, wr_d;
  logic [`CFQ_CNT_W-1:0]  count_q, count_d;
  logic                   dropped_q, dropped_d;
  logic                   full, take, do_pop, drop_head;

  assign q.count    = count_q;
  assign q.empty    = (count_q == '0);
  assign q.head_rec = mem[rd_q];
  assign q.dropped  = dropped_q;

  // Full counts against the configured capacity, so a lowered limit acts at once
  always_comb begin
    full      = (count_q >= q.limit);
    do_pop    = q.pop && !q.empty;
    // A zero capacity admits nothing, whichever full policy is chosen
    take      = q.push_valid && (q.limit != '0) && (!full || do_pop || q.drop_old); // [RULE7]
    drop_head = take && full && !do_pop && !q.empty;               // [RULE7]
    rd_d      = rd_q;
    wr_d      = wr_q;
    count_d   = count_q;
    dropped_d = (q.push_valid && !take) || drop_head;
    if (q.flush) begin
      rd_d      = wr_q;                                            // [RULE8]
      count_d   = '0;
      dropped_d = 1'b0;
    end else begin
      if (take) begin
        wr_d = wr_q + `CFQ_PTR_W'(1);
      end
      if (do_pop || drop_head) begin
        rd_d = rd_q + `CFQ_PTR_W'(1);
      end
      if (take && !(do_pop || drop_head)) begin
        count_d = count_q + `CFQ_CNT_W'(1);
      end else if (!take && do_pop) begin
        count_d = count_q - `CFQ_CNT_W'(1);
      end
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q      <= '0;
      wr_q      <= '0;
      count_q   <= '0;
      dropped_q <= 1'b0;
    end else begin
      rd_q      <= rd_d;
      wr_q      <= wr_d;
      count_q   <= count_d;
      dropped_q <= dropped_d;
    end
  end

  // Storage has no reset; a slot is read only after it was written
  always_ff @(posedge clk) begin
    if (take && !q.flush) begin
      mem[wr_q] <= q.push_rec;
    end
  end
endmodule // cfq_queue

// ---- verif/cfq_asserts.sv ----
// Port-level checker for the CAN port frame block, bound to its top.
// Assumes one clock, CLOCK, and the asynchronous active-low reset RSTN.
`timescale 1ns/1ps
module cfq_asserts (
  input wire logic              CLOCK,
  input wire logic              RSTN,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              CAN_RX_VALID,
  input wire cfq_pkg::cfq_rec_t CAN_RX_REC,
  input wire logic              FIB_TX_VALID,
  input wire cfq_pkg::cfq_rec_t FIB_TX_REC,
  input wire logic              CAN_TX_VALID,
  input wire cfq_pkg::cfq_rec_t CAN_TX_REC,
  input wire logic              CAN_TX_READY,
  input wire logic              CONN_OPEN_REQ,
  input wire logic              CONN_GRANT,
  input wire logic              CONN_REJECT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // Settings reach storage only through the one-wait-state handshake
  a_apb_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("APB answer not in second access cycle");
  a_pready_pulse: assert property (PREADY |=> !PREADY)
    else $error("PREADY longer than one cycle");
  a_slverr_ready: assert property (PSLVERR |-> PREADY)
    else $error("PSLVERR without PREADY");
  // A fiber frame only ever follows a CAN frame one cycle earlier
  a_fib_cause: assert property (FIB_TX_VALID |-> $past(CAN_RX_VALID))
    else $error("Fiber frame without CAN frame");
  a_fib_record: assert property (FIB_TX_VALID |-> FIB_TX_REC == $past(CAN_RX_REC))
    else $error("Fiber record differs from CAN record");
  // Offered frame stays put until taken; a connect flush may cancel it
  a_can_hold: assert property (CAN_TX_VALID && !CAN_TX_READY && !CONN_OPEN_REQ && !CONN_GRANT
    |=> CAN_TX_VALID && $stable(CAN_TX_REC))
    else $error("Offered CAN frame changed before taken");
  a_conn_answer: assert property (CONN_OPEN_REQ |=> CONN_GRANT != CONN_REJECT)
    else $error("Open request not answered once");
  a_conn_cause: assert property (CONN_GRANT || CONN_REJECT |-> $past(CONN_OPEN_REQ))
    else $error("Connection answer without request");
  c_filtered: cover property (CAN_RX_VALID ##1 !FIB_TX_VALID);
  c_reject: cover property (CONN_REJECT);
  c_stall: cover property (CAN_TX_VALID && !CAN_TX_READY [*3]);
endmodule // cfq_asserts

bind cfq_top cfq_asserts u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CAN_RX_VALID(CAN_RX_VALID), .CAN_RX_REC(CAN_RX_REC),
  .FIB_TX_VALID(FIB_TX_VALID), .FIB_TX_REC(FIB_TX_REC), .CAN_TX_VALID(CAN_TX_VALID),
  .CAN_TX_REC(CAN_TX_REC), .CAN_TX_READY(CAN_TX_READY), .CONN_OPEN_REQ(CONN_OPEN_REQ),
  .CONN_GRANT(CONN_GRANT), .CONN_REJECT(CONN_REJECT));

// ---- verif/cfq_can_sink.sv ----
// CAN controller model: takes offered frames at its own pace and logs their IDs.
// Assumes the bench raises stall to imitate a slow bus.
`timescale 1ns/1ps
module cfq_can_sink (
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire logic              valid,
  input  wire cfq_pkg::cfq_rec_t rec,
  output logic                   ready
);
  logic [31:0] got [$];
  initial ready = 1'b0;
  // Ready lags stall by a cycle, like a controller busy on the wire
  always @(posedge clk) begin
    if (valid && ready)
      got.push_back(rec[95:64]);
    ready <= !stall;
  end
endmodule // cfq_can_sink

// ---- verif/tb.sv ----
// Self-checking bench for the CAN port frame block.
// Assumes the checker is bound to the top and the CAN sink model sits on the CAN side.
`timescale 1ns/1ps
module tb;
  logic clk, rstn, psel, pen, pwr, crv, frv, opn, cls, stall;
  logic [11:0] padr;
  logic [31:0] pwd, prd, rd;
  logic        prdy, perr, ftv, ctv, ctr, gnt, rej, er;
  cfq_pkg::cfq_rec_t crr, ftr, frr, ctx;
  int mismatches, checked, drops, filt;
  cfq_top dut (.CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .CAN_RX_VALID(crv), .CAN_RX_REC(crr), .FIB_TX_VALID(ftv), .FIB_TX_REC(ftr),
    .FIB_RX_VALID(frv), .FIB_RX_REC(frr), .CAN_TX_VALID(ctv), .CAN_TX_REC(ctx),
    .CAN_TX_READY(ctr), .CONN_OPEN_REQ(opn), .CONN_CLOSE(cls), .CONN_GRANT(gnt),
    .CONN_REJECT(rej));
  cfq_can_sink u_sink (.clk(clk), .stall(stall), .valid(ctv), .rec(ctx), .ready(ctr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for PREADY under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int k = 0; k <= 20; k++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
      if (k == 20) begin mismatches++; conclude(); end
    end
    rd = prd; er = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  function automatic cfq_pkg::cfq_rec_t mk(input logic ff, input logic [28:0] id);
    return {ff, 1'b0, 2'h0, 4'h8, 3'h0, id, 64'h1122334455667788};
  endfunction
  // CAN frame in; the fiber side must show it next cycle or never
  task automatic can_in(input logic ff, input logic [28:0] id, input logic pass);
    @(posedge clk);
    crv <= 1'b1; crr <= mk(ff, id);
    @(posedge clk);
    crv <= 1'b0;
    #1 cmp({31'h0, ftv}, {31'h0, pass});
    if (pass) cmp(ftr[95:64], {3'h0, id});
    if (!pass) filt++;
  endtask
  // Back-to-back fiber frames with IDs base..base+n-1
  task automatic fib_in(input int n, input logic [28:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      frv <= 1'b1; frr <= mk(1'b0, base + 29'(i));
    end
    @(posedge clk);
    frv <= 1'b0;
  endtask
  task automatic wait_got(input int n);
    for (int k = 0; u_sink.got.size() < n; k++) begin
      if (k == 2000) begin mismatches++; conclude(); end
      @(posedge clk);
    end
  endtask
  task automatic conn(input logic g);
    @(posedge clk);
    opn <= 1'b1;
    @(posedge clk);
    opn <= 1'b0;
    #1 cmp({gnt, rej}, {g, !g});
  endtask
  task automatic t_defaults();
    apb(1'b0, 12'h000, 32'h0); cmp(rd, 32'h00000004);
    apb(1'b0, 12'h008, 32'h0); cmp(rd, 32'h000007FF);
    apb(1'b0, 12'h004, 32'h0); cmp(rd, 32'h00000000);
    apb(1'b0, 12'h010, 32'h0); cmp(rd, 32'h1FFFFFFF);
    apb(1'b0, 12'h00C, 32'h0); cmp(rd, 32'h00000000);
    apb(1'b0, 12'h014, 32'h0); cmp(rd, 32'h0000FFFF);
    apb(1'b0, 12'h018, 32'h0); cmp(rd, 32'h00000001);
    apb(1'b0, 12'h024, 32'h0); cmp({rd[30:0], er}, 32'h1);
    apb(1'b1, 12'h024, 32'h1); cmp({31'h0, er}, 32'h1);
  endtask
  // Filter off passes all; then inclusive ranges chosen by the format flag
  task automatic t_filter();
    logic [28:0] ids [9] = '{29'h0FF, 29'h100, 29'h200, 29'h201, 29'h150,
                             29'hFFFF, 29'h10000, 29'h20000, 29'h20001};
    logic [8:0] ffs = 9'b1_1110_0000;
    logic [8:0] ok  = 9'b0_1101_0110;
    can_in(1'b1, 29'h1FFFFFFF, 1'b1);
    can_in(1'b0, 29'h7FF, 1'b1);
    apb(1'b1, 12'h004, 32'h100); apb(1'b1, 12'h008, 32'h200);
    apb(1'b1, 12'h00C, 32'h10000); apb(1'b1, 12'h010, 32'h20000);
    apb(1'b1, 12'h000, 32'h5);
    for (int i = 0; i < 9; i++)
      can_in(ffs[i], ids[i], ok[i]);
    apb(1'b0, 12'h020, 32'h0); cmp({16'h0, rd[31:16]}, 32'(filt));
  endtask
  // Ten-frame queue under a stalled bus, both full policies
  task automatic t_full();
    apb(1'b1, 12'h014, 32'h1);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, p ? 32'h7 : 32'h5);
      stall <= 1'b1;
      u_sink.got.delete();
      fib_in(12, 29'h7F0);
      drops++;
      apb(1'b0, 12'h01C, 32'h0); cmp({25'h0, rd[6:0]}, 32'd10);
      apb(1'b0, 12'h020, 32'h0); cmp({16'h0, rd[15:0]}, 32'(drops));
      stall <= 1'b0;
      wait_got(11);
      for (int i = 0; i < 11; i++)
        cmp(u_sink.got[i], 32'h7F0 + ((p && i > 0) ? i + 1 : i));
    end
    apb(1'b1, 12'h014, 32'hFFFF);
  endtask
  // Connect with flush on, then with flush off
  task automatic t_flush();
    apb(1'b1, 12'h000, 32'h5);
    stall <= 1'b1;
    u_sink.got.delete();
    fib_in(3, 29'h40);
    conn(1'b1);
    #1 cmp({31'h0, ctv}, 32'h0);
    apb(1'b0, 12'h01C, 32'h0); cmp({25'h0, rd[6:0]}, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    fib_in(2, 29'h50);
    conn(1'b1);
    apb(1'b0, 12'h01C, 32'h0); cmp({25'h0, rd[6:0]}, 32'h1);
    stall <= 1'b0;
    wait_got(2);
    cmp(u_sink.got.size(), 32'd2);
    cmp(u_sink.got[0], 32'h50);
    cmp(u_sink.got[1], 32'h51);
  endtask
  // Server limit of 200, then client segments clamped to 6
  task automatic t_limits();
    for (int i = 2; i < 200; i++)
      conn(1'b1);
    conn(1'b0);
    apb(1'b0, 12'h01C, 32'h0); cmp({24'h0, rd[23:16]}, 32'd200);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      cls <= 1'b1;
    end
    @(posedge clk);
    cls <= 1'b0;
    apb(1'b1, 12'h000, 32'h11);
    apb(1'b1, 12'h018, 32'h7);
    apb(1'b0, 12'h018, 32'h0); cmp(rd, 32'h6);
    for (int i = 0; i < 6; i++)
      conn(1'b1);
    conn(1'b0);
    // UDP mode: a granted open never flushes, even with the flush bit set
    @(posedge clk);
    cls <= 1'b1;
    @(posedge clk);
    cls <= 1'b0;
    apb(1'b1, 12'h000, 32'h25);
    stall <= 1'b1;
    fib_in(2, 29'h60);
    conn(1'b1);
    #1 cmp({31'h0, ctv}, 32'h1);
    apb(1'b0, 12'h01C, 32'h0); cmp({25'h0, rd[6:0]}, 32'h1);
    stall <= 1'b0;
  endtask
  initial begin
    {rstn, psel, pen, pwr, crv, frv, opn, cls, stall} = '0;
    {padr, pwd, crr, frr} = '0;
    {mismatches, checked, drops, filt} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_defaults();
    t_filter();
    t_full();
    t_flush();
    t_limits();
    conclude();
  end
  // Whole-run guard against a hang
  initial begin
    #800000;
    mismatches++;
    conclude();
  end
endmodule // tb
